/* switch_spi_config_status.sv */
`timescale 1ns/100ps
`default_nettype none
module switch_spi_config_status (
    // System clock and reset
    input wire logic CLK_SYS_IN,
    input wire logic RST_N_IN,
    // Serial link, clocked by the host
    input wire logic SCLK_IN,
    input wire logic CHIP_SELECT_N_IN,
    input wire logic SERIAL_IN,
    output logic SERIAL_OUT,
    output logic SERIAL_OUT_EN_OUT,
    // Power die monitors and direct pins
    input wire switch_cfg_pkg::monitor_t MONITOR_IN,
    input wire switch_cfg_pkg::direct_pins_t DIRECT_PINS_IN,
    // Output drive and configuration to the power die
    output logic [11:0] OUTPUT_ON_OUT,
    output logic [3:0] HS_OPEN_LOAD_DIS_OUT,
    output logic [11:4] LS_OPEN_LOAD_EN_OUT,
    output logic [3:0] HS_SUSTAIN_LIMIT_OUT,
    output logic [11:4] LS_OVERCURRENT_SD_EN_OUT,
    output logic FAULT_FLAG_N_OUT
);
    import switch_cfg_pkg::*;

    // Two clock domains live here. The link side runs on the host's serial clock
    // and exists only while chip select is low; the system side owns every register.
    // A finished frame crosses as a captured word plus a toggle, so the system side
    // never samples a half-shifted word. The status word goes the other way as a
    // level: its sources hold still while a frame is open.
    // Trade-off: registers update a few system cycles after chip select rises, so a
    // host that reads back at once may still see the old drive for that short while.
    // Limitation: the host must leave chip select high long enough for that hand-off.

    // Command address field of a received word, decoded in more than one place
    function automatic logic [2:0] addr_of(input logic [15:0] w);
        addr_of = w[ADDR_MSB:ADDR_LSB];
    endfunction : addr_of

    // ---------------- System domain ----------------
    // Configuration and command state
    logic [11:0] output_command_reg_r;
    logic [11:0] open_load_detect_config_r;
    logic [11:0] current_limit_config_r;
    logic wdog_echo_r;

    // Fault bookkeeping
    logic [11:0] status_fault_bits_r;
    logic [11:0] fault_snap_r;
    logic [11:0] ol_clear_pend_r;
    logic [11:0] fault_now;
    logic [11:0] ol_qualified;

    // Synchronisers for pins, monitors and chip select
    logic [5:0] direct_meta_r;
    logic [5:0] direct_sync_r;
    monitor_t mon_meta_r;
    monitor_t mon_sync_r;
    logic cs_meta_r;
    logic cs_sync_r;
    logic cs_sync_d_r;

    // Frame hand-off from the link domain
    logic [1:0] frame_tgl_meta_r;
    logic frame_tgl_sync_r;
    logic frame_tgl_seen_r;
    frame_t frame_r;
    logic frame_tgl_r;
    logic frame_evt;
    logic write_ok;

    // Decoded conditions
    logic [11:0] drive_nxt;
    logic off_all;
    logic logic_reinit;
    monitor_t mon;
    direct_pins_t pins;
    logic cs_fall_sys;
    logic cs_rise_sys;

    // Synchronised views and edge detects
    assign mon = mon_sync_r;
    assign pins = direct_pins_t'(direct_sync_r);
    assign logic_reinit = mon.below_5v;
    assign off_all = mon.gnd_lost | mon.below_6v;
    assign frame_evt = frame_tgl_sync_r ^ frame_tgl_seen_r;
    // A frame counts only when its length was a whole number of words
    assign write_ok = frame_evt & frame_r.valid_len;
    assign cs_fall_sys = cs_sync_d_r & ~cs_sync_r;
    assign cs_rise_sys = ~cs_sync_d_r & cs_sync_r;

    // Direct input pins: two flops before the status word reads them
    always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            direct_meta_r <= 6'h00;
            direct_sync_r <= 6'h00;
        end else begin
            direct_meta_r <= DIRECT_PINS_IN;
            direct_sync_r <= direct_meta_r;
        end
    end

    // Power die monitors: levels, so a plain two-flop chain is enough
    always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            mon_meta_r <= '0;
            mon_sync_r <= '0;
        end else begin
            mon_meta_r <= MONITOR_IN;
            mon_sync_r <= mon_meta_r;
        end
    end

    // Chip select: a third flop feeds the edge detects. Its idle level is high, so
    // all three reset high and no false falling edge follows reset.
    always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            cs_meta_r <= 1'h1;
            cs_sync_r <= 1'h1;
            cs_sync_d_r <= 1'h1;
        end else begin
            cs_meta_r <= CHIP_SELECT_N_IN;
            cs_sync_r <= cs_meta_r;
            cs_sync_d_r <= cs_sync_r;
        end
    end

    // Frame toggle: three stages, then one that remembers the toggle already seen
    always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            frame_tgl_meta_r <= 2'h0;
            frame_tgl_sync_r <= 1'h0;
            frame_tgl_seen_r <= 1'h0;
        end else begin
            frame_tgl_meta_r <= {frame_tgl_meta_r[0], frame_tgl_r};
            frame_tgl_sync_r <= frame_tgl_meta_r[1];
            frame_tgl_seen_r <= frame_tgl_sync_r;
        end
    end

    // Present faults: open load only while off and detection enabled
    // High sides use a disable bit, low sides an enable bit, so the polarity differs.
    // Over temperature of an output commanded off is not a reportable fault here.
    // Overvoltage overrides everything: all twelve bits at once mark it.
    always_comb begin
        for (int i = 0; i < OUT_COUNT; i++) begin
            if (i < HS_COUNT) begin
                ol_qualified[i] = mon.open_load[i] & ~output_command_reg_r[i]
                                  & ~open_load_detect_config_r[i];
            end else begin
                ol_qualified[i] = mon.open_load[i] & ~output_command_reg_r[i]
                                  & open_load_detect_config_r[i];
            end
        end
        // Over temperature counts only while commanded on; current limit never does
        fault_now = ol_qualified | (mon.over_temp & output_command_reg_r);
        if (mon.over_voltage) begin
            fault_now = 12'hFFF;
        end
    end

    // Configuration registers written at the end of a valid frame
    // Only the last sixteen bits of a long frame count as the command.
    // Addresses owned by other blocks fall through to the default and change nothing.
    // Reinitialisation at low supply takes priority over any pending write.
    always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            output_command_reg_r <= OUTPUT_CMD_RST;
            open_load_detect_config_r <= OPEN_LOAD_RST;
            current_limit_config_r <= CUR_LIMIT_RST;
            wdog_echo_r <= 1'h0;
        end else if (logic_reinit) begin
            output_command_reg_r <= OUTPUT_CMD_RST;
            open_load_detect_config_r <= OPEN_LOAD_RST;
            current_limit_config_r <= CUR_LIMIT_RST;
            wdog_echo_r <= 1'h0;
        end else if (write_ok) begin
            case (addr_of(frame_r.word))
                ADDR_OUTPUT_CMD: begin
                    output_command_reg_r <= frame_r.word[11:0];
                    wdog_echo_r <= frame_r.word[WDOG_BIT];
                end
                ADDR_OPEN_LOAD: begin
                    open_load_detect_config_r <= frame_r.word[11:0];
                end
                ADDR_CUR_LIMIT: begin
                    current_limit_config_r <= frame_r.word[11:0];
                end
                // Unused and factory test slots are blocked; other registers live elsewhere
                default: begin
                end
            endcase
        end
    end

    // Sticky fault capture; set wins over the re-arm clear
    // The snapshot is taken at the synchronised falling edge of chip select, which is
    // why the host must wait before its first clock edge. The re-arm on the rising edge
    // keeps only faults still present, except open loads of outputs just commanded on.
    // Hazard: a fault that comes and goes inside one frame is lost, as the re-arm overwrites the OR.
    always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            status_fault_bits_r <= 12'h000;
            fault_snap_r <= 12'h000;
            ol_clear_pend_r <= 12'h000;
        end else if (logic_reinit) begin
            status_fault_bits_r <= 12'h000;
            fault_snap_r <= 12'h000;
            ol_clear_pend_r <= 12'h000;
        end else begin
            if (cs_fall_sys) begin
                fault_snap_r <= status_fault_bits_r | fault_now;
            end
            if (write_ok && addr_of(frame_r.word) == ADDR_OUTPUT_CMD) begin
                ol_clear_pend_r <= ol_clear_pend_r | (frame_r.word[11:0] & ~output_command_reg_r);
            end else if (cs_rise_sys) begin
                ol_clear_pend_r <= 12'h000;
            end
            if (cs_rise_sys) begin
                status_fault_bits_r <= fault_now & ~(ol_clear_pend_r & ~mon.over_temp);
            end else begin
                status_fault_bits_r <= status_fault_bits_r | fault_now;
            end
        end
    end

    // Output drive: thermal shutdown forces an output off until it cools
    // The sensor flag already carries its hysteresis, so the output returns by itself
    // once the flag drops, unless the command bit was cleared meanwhile.
    // Ground loss and low supply override the command but leave it stored.
    always_comb begin
        drive_nxt = output_command_reg_r & ~mon.over_temp;
        if (off_all) begin
            drive_nxt = 12'h000;
        end
    end

    // Registered outputs to the power die
    // Every output leaves from a flop, so the power die never sees decode glitches.
    // The fault pin lags the monitors by the synchroniser and this stage,
    // a few system cycles, well inside what real-time reporting needs.
    always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            OUTPUT_ON_OUT <= 12'h000;
            HS_OPEN_LOAD_DIS_OUT <= 4'h0;
            LS_OPEN_LOAD_EN_OUT <= 8'h00;
            HS_SUSTAIN_LIMIT_OUT <= 4'h0;
            LS_OVERCURRENT_SD_EN_OUT <= 8'h00;
            FAULT_FLAG_N_OUT <= 1'h1;
        end else begin
            OUTPUT_ON_OUT <= drive_nxt;
            HS_OPEN_LOAD_DIS_OUT <= open_load_detect_config_r[3:0];
            LS_OPEN_LOAD_EN_OUT <= open_load_detect_config_r[11:4];
            HS_SUSTAIN_LIMIT_OUT <= current_limit_config_r[3:0];
            LS_OVERCURRENT_SD_EN_OUT <= current_limit_config_r[11:4];
            FAULT_FLAG_N_OUT <= ~(|fault_now);
        end
    end

    // ---------------- Link domain ----------------
    // Everything below runs on the host's serial clock, which stands still between
    // frames. Chip select high holds this logic in reset, so a frame cut short
    // leaves nothing behind; only the captured word crosses, with its toggle.
    // Input bits are taken on rising edges, output bits change on falling edges,
    // which gives the host half a period of setup on both lines.
    // Status word is built in the system domain and sampled at the first falling link edge;
    // its inputs are quasi-static while chip select is low, so a level crossing suffices.
    logic [15:0] status_word;
    logic [15:0] shift_r;
    logic [15:0] rx_r;
    logic [BITCNT_W-1:0] bit_cnt_r;
    logic past_first_r;
    logic any_bits_r;
    logic link_active_r;

    // Status word: watchdog echo, three selected input pins, then the fault snapshot
    // The echo picks which group of pins is shown, so the host sees all of them
    // over two frames by toggling the watchdog bit.
    always_comb begin
        status_word[WDOG_BIT] = wdog_echo_r;
        if (wdog_echo_r) begin
            status_word[14:12] = {pins.hs_direct_in[2], pins.hs_direct_in[3], pins.wake_input};
        end else begin
            status_word[14:12] = {pins.hs_direct_in[0], pins.hs_direct_in[1], pins.failsafe_input};
        end
        status_word[11:0] = fault_snap_r;
    end

    // Shift engine; chip select high holds it in reset, ending every frame
    // The counter wraps at sixteen; together with the past-first flag it tells
    // whether the length was a whole number of words when chip select rises.
    // Received bits stay here so the daisy chain can replay them.
    always_ff @(posedge SCLK_IN or posedge CHIP_SELECT_N_IN) begin
        if (CHIP_SELECT_N_IN) begin
            rx_r <= 16'h0000;
            bit_cnt_r <= 4'h0;
            past_first_r <= 1'h0;
            any_bits_r <= 1'h0;
        end else begin
            rx_r <= {rx_r[14:0], SERIAL_IN};
            bit_cnt_r <= bit_cnt_r + 4'h1;
            any_bits_r <= 1'h1;
            if (bit_cnt_r == 4'hF) begin
                past_first_r <= 1'h1;
            end
        end
    end

    // Serial out changes on falling edge; first bit shown from the status word when chip select falls
    // The first falling edge loads bits 14..0 of the status word; bit 15 is shown
    // directly before it. After sixteen bits the oldest received bit goes out,
    // one per edge, so a second device in the chain sees its own command.
    always_ff @(negedge SCLK_IN or posedge CHIP_SELECT_N_IN) begin
        if (CHIP_SELECT_N_IN) begin
            shift_r <= 16'h0000;
            link_active_r <= 1'h0;
        end else if (!link_active_r) begin
            shift_r <= {status_word[14:0], 1'h0};
            link_active_r <= 1'h1;
        end else if (past_first_r) begin
            // Daisy chain: the received word replays from its first bit on
            shift_r <= {rx_r[15], shift_r[14:0]};
        end else begin
            shift_r <= {shift_r[14:0], 1'h0};
        end
    end

    // Serial out stays tri-state whenever chip select is high
    // The enable follows the pin itself, not a synchronised copy, so the line is
    // released at once when the frame ends.
    always_comb begin
        SERIAL_OUT = link_active_r ? shift_r[15] : status_word[15];
        SERIAL_OUT_EN_OUT = ~CHIP_SELECT_N_IN;
    end

    // Frame hand-off: capture on chip select rising, toggle crosses to system clock
    // The word and its length flag are read here before the link reset clears them.
    // They then hold still until the next frame ends, long after the system side
    // has seen the toggle, so the multi-bit word needs no gray code.
    // Limitation: frames closer together than the hand-off time may be lost.
    always_ff @(posedge CHIP_SELECT_N_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            frame_r <= '0;
            frame_tgl_r <= 1'h0;
        end else begin
            frame_r.word <= rx_r;
            frame_r.valid_len <= any_bits_r && (bit_cnt_r == 4'h0) && past_first_r;
            frame_tgl_r <= ~frame_tgl_r;
        end
    end
endmodule : switch_spi_config_status
`default_nettype wire

/* switch_cfg_pkg.sv */
package switch_cfg_pkg;
    // Serial word layout
    localparam int WORD_BITS = 16;
    localparam int WDOG_BIT = 15;
    localparam int ADDR_MSB = 14;
    localparam int ADDR_LSB = 12;
    localparam int OUT_COUNT = 12;
    localparam int HS_COUNT = 4;
    localparam int BITCNT_W = 4;
    // Register addresses
    localparam logic [2:0] ADDR_OUTPUT_CMD = 3'h0;
    localparam logic [2:0] ADDR_OPEN_LOAD = 3'h1;
    localparam logic [2:0] ADDR_UNUSED = 3'h3;
    localparam logic [2:0] ADDR_CUR_LIMIT = 3'h5;
    localparam logic [2:0] ADDR_FACTORY_TEST = 3'h7;
    // Reset values
    localparam logic [11:0] OUTPUT_CMD_RST = 12'h000;
    localparam logic [11:0] OPEN_LOAD_RST = 12'h000;
    localparam logic [11:0] CUR_LIMIT_RST = 12'h000;
    // Analog monitor inputs from the power die
    typedef struct packed {
        logic [11:0] over_temp;
        logic [11:0] open_load;
        logic over_voltage;
        logic below_6v;
        logic below_5v;
        logic gnd_lost;
    } monitor_t;
    // Direct input pins echoed in the status word
    typedef struct packed {
        logic [3:0] hs_direct_in;
        logic failsafe_input;
        logic wake_input;
    } direct_pins_t;
    // A finished transfer handed to the system domain
    typedef struct packed {
        logic [15:0] word;
        logic valid_len;
    } frame_t;
endpackage : switch_cfg_pkg

/* switch_spi_chk_props.sv */
`timescale 1ns/100ps
`default_nettype none
module switch_spi_chk (
    // Clock and reset
    input wire logic CLK_SYS_IN,
    input wire logic RST_N_IN,
    // Link select and monitors
    input wire logic CHIP_SELECT_N_IN,
    input wire switch_cfg_pkg::monitor_t MONITOR_IN,
    // Observed outputs
    input wire logic SERIAL_OUT_EN_OUT,
    input wire logic [11:0] OUTPUT_ON_OUT,
    input wire logic [3:0] HS_OPEN_LOAD_DIS_OUT,
    input wire logic [11:4] LS_OPEN_LOAD_EN_OUT,
    input wire logic [3:0] HS_SUSTAIN_LIMIT_OUT,
    input wire logic [11:4] LS_OVERCURRENT_SD_EN_OUT,
    input wire logic FAULT_FLAG_N_OUT
);
    import switch_cfg_pkg::*;
    // Monitors pass two sync flops and one or two registers, so four samples are enough
    default clocking cb @(posedge CLK_SYS_IN); endclocking
    default disable iff (!RST_N_IN);
    logic [23:0] cfg;
    assign cfg = {HS_OPEN_LOAD_DIS_OUT, LS_OPEN_LOAD_EN_OUT, HS_SUSTAIN_LIMIT_OUT, LS_OVERCURRENT_SD_EN_OUT};
    a_so_release: assert property ($past(CHIP_SELECT_N_IN) && CHIP_SELECT_N_IN |-> !SERIAL_OUT_EN_OUT)
        else $error("serial out driven while deselected");
    a_so_drive: assert property (!$past(CHIP_SELECT_N_IN) && !CHIP_SELECT_N_IN |-> SERIAL_OUT_EN_OUT)
        else $error("serial out idle in frame");
    a_gnd_off: assert property (MONITOR_IN.gnd_lost [*4] |=> OUTPUT_ON_OUT == 12'h000)
        else $error("output on after ground loss");
    a_uv_off: assert property (MONITOR_IN.below_6v [*4] |=> OUTPUT_ON_OUT == 12'h000)
        else $error("output on at low supply");
    a_reinit_cfg: assert property (MONITOR_IN.below_5v [*4] |=> cfg == 24'h000000)
        else $error("config kept after reinit");
    a_ov_flag: assert property (MONITOR_IN.over_voltage [*4] |=> !FAULT_FLAG_N_OUT)
        else $error("fault pin high in overvoltage");
    a_flag_idle: assert property ((MONITOR_IN.over_temp == 12'h000 && MONITOR_IN.open_load == 12'h000
        && !MONITOR_IN.over_voltage) [*4] |=> FAULT_FLAG_N_OUT)
        else $error("fault pin low with no fault");
    a_cfg_on_cs: assert property ($changed(cfg) && !MONITOR_IN.below_5v |-> $past(CHIP_SELECT_N_IN, 3))
        else $error("config changed inside a frame");
    c_frame: cover property ($rose(CHIP_SELECT_N_IN));
    c_fault: cover property ($fell(FAULT_FLAG_N_OUT));
    c_reinit: cover property (MONITOR_IN.below_5v [*4]);
endmodule : switch_spi_chk
bind switch_spi_config_status switch_spi_chk u_chk (.CLK_SYS_IN(CLK_SYS_IN), .RST_N_IN(RST_N_IN),
    .CHIP_SELECT_N_IN(CHIP_SELECT_N_IN), .MONITOR_IN(MONITOR_IN), .SERIAL_OUT_EN_OUT(SERIAL_OUT_EN_OUT),
    .OUTPUT_ON_OUT(OUTPUT_ON_OUT), .HS_OPEN_LOAD_DIS_OUT(HS_OPEN_LOAD_DIS_OUT),
    .LS_OPEN_LOAD_EN_OUT(LS_OPEN_LOAD_EN_OUT), .HS_SUSTAIN_LIMIT_OUT(HS_SUSTAIN_LIMIT_OUT),
    .LS_OVERCURRENT_SD_EN_OUT(LS_OVERCURRENT_SD_EN_OUT), .FAULT_FLAG_N_OUT(FAULT_FLAG_N_OUT));
`default_nettype wire

/* host_spi_model.sv */
`timescale 1ns/100ps
`default_nettype none
module host_spi_model (
    // Link pins driven by the host
    output logic sclk_out,
    output logic cs_n_out,
    output logic si_out,
    // Device reply
    input wire logic so_in
);
    // Idle link: clock parked low, device deselected
    initial begin
        sclk_out = 1'b0;
        cs_n_out = 1'b1;
        si_out = 1'b0;
    end
    // One frame, MSB first; the clock runs only inside it
    task automatic xfer(input logic [31:0] tx, input int nbits, output logic [31:0] rx);
        rx = 32'h0000_0000;
        cs_n_out = 1'b0;
        #20;
        for (int i = nbits - 1; i >= 0; i--) begin
            si_out = tx[i];
            #15;
            rx = {rx[30:0], so_in};
            sclk_out = 1'b1;
            #15;
            sclk_out = 1'b0;
        end
        // Data line means nothing now, so show the inverse rather than a stale bit
        si_out = ~si_out;
        cs_n_out = 1'b1;
        #60;
    endtask : xfer
endmodule : host_spi_model
`default_nettype wire

/* switch_spi_config_status_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module switch_spi_config_status_tb;
    import switch_cfg_pkg::*;
    logic clk, rst_n, sclk, cs_n, si, so, so_en, flag_n, echo;
    wire so_line;
    monitor_t mon;
    direct_pins_t pins;
    logic [11:0] on_q;
    logic [3:0] hs_dis, hs_sus;
    logic [11:4] ls_en, ls_oc;
    logic [31:0] rx;
    int n_errors, tests_run, cyc;
    switch_spi_config_status uut (.CLK_SYS_IN(clk), .RST_N_IN(rst_n), .SCLK_IN(sclk), .CHIP_SELECT_N_IN(cs_n),
        .SERIAL_IN(si), .SERIAL_OUT(so), .SERIAL_OUT_EN_OUT(so_en), .MONITOR_IN(mon), .DIRECT_PINS_IN(pins),
        .OUTPUT_ON_OUT(on_q), .HS_OPEN_LOAD_DIS_OUT(hs_dis), .LS_OPEN_LOAD_EN_OUT(ls_en),
        .HS_SUSTAIN_LIMIT_OUT(hs_sus), .LS_OVERCURRENT_SD_EN_OUT(ls_oc), .FAULT_FLAG_N_OUT(flag_n));
    host_spi_model host (.sclk_out(sclk), .cs_n_out(cs_n), .si_out(si), .so_in(so_line));
    // Pin floats once the device lets go of it
    assign so_line = so_en ? so : 1'bz;
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // Ceiling well above the few thousand cycles the tests need
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            tally_and_finish();
        end
    end
    task automatic w(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : w
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // Expected status word: echo, selected input pins, fault bits
    function automatic logic [15:0] st(input logic e, input logic [11:0] f);
        st = {e, e ? {pins.hs_direct_in[2], pins.hs_direct_in[3], pins.wake_input}
            : {pins.hs_direct_in[0], pins.hs_direct_in[1], pins.failsafe_input}, f};
    endfunction : st
    task automatic op(input logic wd, input logic [2:0] a, input logic [11:0] d, input logic [11:0] f);
        host.xfer({16'h0000, wd, a, d}, 16, rx);
        chk(rx[15:0], st(echo, f));
        if (a == ADDR_OUTPUT_CMD) echo = wd;
    endtask : op
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        rst_n = 1'b0;
        mon = '0;
        pins = '0;
        pins.hs_direct_in = 4'h9;
        pins.wake_input = 1'b1;
        echo = 1'b0;
        w(20);
        rst_n = 1'b1;
        w(4);
        op(1'b0, ADDR_OPEN_LOAD, 12'hA5F, 12'h000);
        chk({4'h0, ls_en, hs_dis}, 16'h0A5F);
        op(1'b0, ADDR_CUR_LIMIT, 12'h3C9, 12'h000);
        chk({4'h0, ls_oc, hs_sus}, 16'h03C9);
        op(1'b1, ADDR_OUTPUT_CMD, 12'h123, 12'h000);
        chk({4'h0, on_q}, 16'h0123);
        $display("test config done");
        op(1'b0, ADDR_UNUSED, 12'hFFF, 12'h000);
        op(1'b0, ADDR_FACTORY_TEST, 12'hFFF, 12'h000);
        host.xfer(32'h0001_0000, 20, rx);
        host.xfer(32'h0000_0010, 8, rx);
        w(10);
        chk({on_q, hs_dis}, 16'h123F);
        chk({ls_en, ls_oc}, 16'hA53C);
        host.xfer(32'h5ABC_5111, 32, rx);
        chk(rx[31:16], st(echo, 12'h000));
        chk(rx[15:0], 16'h5ABC);
        w(10);
        chk({4'h0, ls_oc, hs_sus}, 16'h0111);
        $display("test frames done");
        // Fault pulses gone before the read must still be reported once
        mon.over_temp = 12'h001;
        w(8);
        chk({15'h0000, flag_n}, 16'h0000);
        mon.over_temp = 12'h000;
        w(8);
        op(1'b1, ADDR_UNUSED, 12'h000, 12'h001);
        op(1'b1, ADDR_UNUSED, 12'h000, 12'h000);
        mon.over_voltage = 1'b1;
        w(8);
        mon.over_voltage = 1'b0;
        w(8);
        op(1'b1, ADDR_UNUSED, 12'h000, 12'hFFF);
        mon.open_load = 12'h031;
        w(8);
        mon.open_load = 12'h000;
        w(8);
        op(1'b1, ADDR_UNUSED, 12'h000, 12'h010);
        $display("test faults done");
        mon.below_6v = 1'b1;
        w(8);
        chk({4'h0, on_q}, 16'h0000);
        mon.below_6v = 1'b0;
        w(8);
        chk({4'h0, on_q}, 16'h0123);
        mon.gnd_lost = 1'b1;
        w(8);
        chk({4'h0, on_q}, 16'h0000);
        mon.gnd_lost = 1'b0;
        mon.below_5v = 1'b1;
        w(8);
        mon.below_5v = 1'b0;
        w(8);
        echo = 1'b0;
        chk({on_q, hs_dis}, 16'h0000);
        chk({ls_en, ls_oc}, 16'h0000);
        op(1'b0, ADDR_UNUSED, 12'h000, 12'h000);
        $display("test supply done");
        tally_and_finish();
    end
endmodule : switch_spi_config_status_tb
`default_nettype wire
